//--- logic/rht_target.sv
// serial command target: bus slave, command sequencer, response buffer
// assumes scl/sda arrive from pins, sensor words come on ref_clk_i
`timescale 1ns/1ps

module rht_fifo #(
    parameter int W = 24,
    parameter int D = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign in_ready_o = (cnt_r != (AW+1)'(D));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem[rp_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || flush_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : rht_fifo

////////////////////////////////////////////////////////////////////////
module rht_target #(
    parameter logic [6:0] TGT_ADDR = 7'h40,
    parameter int RST_CNT =
        rht_pkg::SOFT_RESET_RECOVERY_TIME_US * rht_pkg::CLK_MHZ,
    parameter int LOW_CNT =
        rht_pkg::LOW_REPEAT_MEASURE_TIME_US * rht_pkg::CLK_MHZ,
    parameter int MID_CNT =
        rht_pkg::MID_REPEAT_MEASURE_TIME_US * rht_pkg::CLK_MHZ,
    parameter int HIGH_CNT =
        rht_pkg::HIGH_REPEAT_MEASURE_TIME_US * rht_pkg::CLK_MHZ,
    parameter int LONG_CNT = rht_pkg::HEATER_PULSE_TIME_LONG_MS
        * rht_pkg::US_PER_MS * rht_pkg::CLK_MHZ,
    parameter int SHORT_CNT = rht_pkg::HEATER_PULSE_TIME_SHORT_MS
        * rht_pkg::US_PER_MS * rht_pkg::CLK_MHZ
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [15:0] temp_word_i,
    input wire logic [15:0] relative_humidity_word_i,
    input wire logic [31:0] serial_num_i,
    output logic meas_req_o,
    output logic [1:0] meas_rep_o,
    output logic heater_on_o,
    output logic [1:0] heater_pwr_o,
    output logic busy_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = rht_pkg::CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ rht_pkg::CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c ^ rht_pkg::CRC_XOR;
    endfunction : crc8

    ////////////////////////////////////////////////////////////////////
    // pin sampling; 100 MHz oversamples every bus speed
    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    assign scl = scl_s_r[1];
    assign sda = sda_s_r[1];
    assign scl_rise = scl & ~scl_d_r;
    assign scl_fall = ~scl & scl_d_r;
    assign start_ev = scl & scl_d_r & sda_d_r & ~sda;
    assign stop_ev = scl & scl_d_r & ~sda_d_r & sda;

    ////////////////////////////////////////////////////////////////////
    // bus slave
    rht_pkg::rht_bus_e bst_r;
    rht_pkg::rht_op_e ost_r;
    logic [2:0] bcnt_r;
    logic [7:0] sh_r;
    logic full_r;
    logic rd_r;
    logic gc_r;
    logic rd_hit_r;
    logic oe_n_r;
    logic [1:0] idx_r;
    logic busy;
    logic ack_ok;
    logic load_ev;
    logic cmd_ev;
    logic flush;
    logic [7:0] tx_byte;
    logic f_in_valid;
    logic f_in_ready;
    logic [23:0] f_in_data;
    logic f_out_valid;
    logic f_pop;
    logic [23:0] f_out_data;

    assign busy = (ost_r != rht_pkg::O_IDLE);
    always_comb begin
        if (bst_r == rht_pkg::B_ADDR) begin
            ack_ok = (sh_r[7:1] == TGT_ADDR && !(sh_r[0] && busy))
                || sh_r == {rht_pkg::GC_ADDR, 1'b0};
        end else begin
            ack_ok = 1'b1;
        end
    end
    assign load_ev = scl_fall && ((bst_r == rht_pkg::B_ACK && rd_r)
        || bst_r == rht_pkg::B_MACK);
    assign cmd_ev = scl_fall && full_r && bst_r == rht_pkg::B_WR;
    // empty buffer reads as idle bus ones
    always_comb begin
        unique case (idx_r)
            2'h0: tx_byte = f_out_data[23:16];
            2'h1: tx_byte = f_out_data[15:8];
            default: tx_byte = f_out_data[7:0];
        endcase
        if (!f_out_valid) begin
            tx_byte = 8'hff;
        end
    end
    assign f_pop = load_ev && idx_r == rht_pkg::LAST_BYTE;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bst_r <= rht_pkg::B_IDLE;
            bcnt_r <= 3'h0;
            sh_r <= 8'h00;
            full_r <= 1'b0;
            rd_r <= 1'b0;
            gc_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (start_ev) begin
            bst_r <= rht_pkg::B_ADDR;
            bcnt_r <= 3'h0;
            full_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (stop_ev) begin
            bst_r <= rht_pkg::B_IDLE;
            oe_n_r <= 1'b1;
        end else begin
            unique case (bst_r)
                rht_pkg::B_IDLE, rht_pkg::B_SKIP: begin
                end
                rht_pkg::B_ADDR, rht_pkg::B_WR: begin
                    if (scl_rise) begin
                        sh_r <= {sh_r[6:0], sda};
                        bcnt_r <= bcnt_r + 3'h1;
                        full_r <= (bcnt_r == 3'h7);
                    end else if (scl_fall && full_r) begin
                        full_r <= 1'b0;
                        if (ack_ok) begin
                            oe_n_r <= 1'b0;
                            bst_r <= rht_pkg::B_ACK;
                        end else begin
                            bst_r <= rht_pkg::B_SKIP;
                        end
                        if (bst_r == rht_pkg::B_ADDR) begin
                            rd_r <= sh_r[0];
                            gc_r <= (sh_r[7:1] == rht_pkg::GC_ADDR);
                        end
                    end
                end
                rht_pkg::B_ACK: begin
                    if (scl_fall && rd_r) begin
                        sh_r <= tx_byte;
                        oe_n_r <= tx_byte[7];
                        bcnt_r <= 3'h0;
                        bst_r <= rht_pkg::B_RD;
                    end else if (scl_fall) begin
                        oe_n_r <= 1'b1;
                        bcnt_r <= 3'h0;
                        bst_r <= rht_pkg::B_WR;
                    end
                end
                rht_pkg::B_RD: begin
                    if (scl_rise) begin
                        bcnt_r <= bcnt_r + 3'h1;
                    end else if (scl_fall && bcnt_r == 3'h0) begin
                        oe_n_r <= 1'b1;
                        bst_r <= rht_pkg::B_MACK;
                    end else if (scl_fall) begin
                        sh_r <= {sh_r[6:0], 1'b1};
                        oe_n_r <= sh_r[6];
                    end
                end
                rht_pkg::B_MACK: begin
                    if (scl_rise && sda) begin
                        bst_r <= rht_pkg::B_SKIP;
                    end else if (scl_fall) begin
                        sh_r <= tx_byte;
                        oe_n_r <= tx_byte[7];
                        bst_r <= rht_pkg::B_RD;
                    end
                end
                default: bst_r <= rht_pkg::B_IDLE;
            endcase
        end
    end

    // data leave once the acked read ends, even part-read
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_ev || stop_ev) begin
            idx_r <= 2'h0;
        end else if (load_ev) begin
            idx_r <= f_pop ? 2'h0 : idx_r + 2'h1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start_ev || stop_ev) begin
            rd_hit_r <= 1'b0;
        end else if (bst_r == rht_pkg::B_ACK && rd_r && !gc_r) begin
            rd_hit_r <= 1'b1;
        end
    end
    // a new command drops unread words; a full buffer would stall the fill
    assign flush = ((start_ev || stop_ev) && rd_hit_r)
        || (cmd_ev && !gc_r && !busy)
        || ost_r == rht_pkg::O_RST;

    // clock is input only; only sda is ever pulled low
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            sda_o <= 1'b0;
            sda_oe_n_o <= oe_n_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command sequencer
    logic [31:0] tmr_r;
    logic [15:0] t_q_r;
    logic [15:0] h_q_r;
    logic heater_r;
    logic [1:0] rep_r;
    logic [7:0] cmd;
    assign cmd = sh_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ost_r <= rht_pkg::O_IDLE;
            tmr_r <= 32'h0;
            t_q_r <= 16'h0;
            h_q_r <= 16'h0;
            heater_r <= 1'b0;
            heater_pwr_o <= rht_pkg::PWR_OFF;
            rep_r <= rht_pkg::REP_LOW;
            meas_req_o <= 1'b0;
        end else if (cmd_ev && (gc_r ? cmd == rht_pkg::GC_RESET
                : cmd == rht_pkg::CMD_SOFT_RST)) begin
            ost_r <= rht_pkg::O_RST;
            tmr_r <= 32'(RST_CNT - 1);
            heater_r <= 1'b0;
            heater_pwr_o <= rht_pkg::PWR_OFF;
            meas_req_o <= 1'b0;
        end else if (cmd_ev && !gc_r && !busy) begin
            unique case (cmd)
                rht_pkg::CMD_MEAS_HIGH: begin
                    ost_r <= rht_pkg::O_MEAS;
                    rep_r <= rht_pkg::REP_HIGH;
                    tmr_r <= 32'(HIGH_CNT - 1);
                    meas_req_o <= 1'b1;
                end
                rht_pkg::CMD_MEAS_MID: begin
                    ost_r <= rht_pkg::O_MEAS;
                    rep_r <= rht_pkg::REP_MID;
                    tmr_r <= 32'(MID_CNT - 1);
                    meas_req_o <= 1'b1;
                end
                rht_pkg::CMD_MEAS_LOW: begin
                    ost_r <= rht_pkg::O_MEAS;
                    rep_r <= rht_pkg::REP_LOW;
                    tmr_r <= 32'(LOW_CNT - 1);
                    meas_req_o <= 1'b1;
                end
                rht_pkg::CMD_SERIAL: begin
                    ost_r <= rht_pkg::O_FILL_T;
                    t_q_r <= serial_num_i[31:16];
                    h_q_r <= serial_num_i[15:0];
                end
                rht_pkg::CMD_HEAT_LONG_HI, rht_pkg::CMD_HEAT_LONG_MID,
                rht_pkg::CMD_HEAT_LONG_LO: begin
                    ost_r <= rht_pkg::O_HEAT;
                    heater_r <= 1'b1;
                    tmr_r <= 32'(LONG_CNT - 1);
                    heater_pwr_o <= cmd == rht_pkg::CMD_HEAT_LONG_HI ?
                        rht_pkg::PWR_HI : cmd == rht_pkg::CMD_HEAT_LONG_MID ?
                        rht_pkg::PWR_MID : rht_pkg::PWR_LO;
                end
                rht_pkg::CMD_HEAT_SHORT_HI, rht_pkg::CMD_HEAT_SHORT_MID,
                rht_pkg::CMD_HEAT_SHORT_LO: begin
                    ost_r <= rht_pkg::O_HEAT;
                    heater_r <= 1'b1;
                    tmr_r <= 32'(SHORT_CNT - 1);
                    heater_pwr_o <= cmd == rht_pkg::CMD_HEAT_SHORT_HI ?
                        rht_pkg::PWR_HI : cmd == rht_pkg::CMD_HEAT_SHORT_MID ?
                        rht_pkg::PWR_MID : rht_pkg::PWR_LO;
                end
                default: begin
                end
            endcase
        end else begin
            unique case (ost_r)
                rht_pkg::O_IDLE: begin
                end
                rht_pkg::O_HEAT: begin
                    tmr_r <= tmr_r - 32'h1;
                    if (tmr_r == 32'h0) begin
                        ost_r <= rht_pkg::O_MEAS;
                        rep_r <= rht_pkg::REP_HIGH;
                        tmr_r <= 32'(HIGH_CNT - 1);
                        meas_req_o <= 1'b1;
                    end
                end
                rht_pkg::O_MEAS: begin
                    tmr_r <= tmr_r - 32'h1;
                    if (tmr_r == 32'h0) begin
                        ost_r <= rht_pkg::O_FILL_T;
                        meas_req_o <= 1'b0;
                        heater_r <= 1'b0;
                        heater_pwr_o <= rht_pkg::PWR_OFF;
                        t_q_r <= temp_word_i;
                        h_q_r <= relative_humidity_word_i;
                    end
                end
                rht_pkg::O_FILL_T: begin
                    if (f_in_ready) begin
                        ost_r <= rht_pkg::O_FILL_H;
                    end
                end
                rht_pkg::O_FILL_H: begin
                    if (f_in_ready) begin
                        ost_r <= rht_pkg::O_IDLE;
                    end
                end
                rht_pkg::O_RST: begin
                    tmr_r <= tmr_r - 32'h1;
                    if (tmr_r == 32'h0) begin
                        ost_r <= rht_pkg::O_IDLE;
                    end
                end
                default: ost_r <= rht_pkg::O_IDLE;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            heater_on_o <= 1'b0;
            meas_rep_o <= rht_pkg::REP_LOW;
        end else begin
            busy_o <= busy;
            heater_on_o <= heater_r;
            meas_rep_o <= rep_r;
        end
    end

    // stalls fill states until a slot frees
    assign f_in_valid = ost_r == rht_pkg::O_FILL_T
        || ost_r == rht_pkg::O_FILL_H;
    always_comb begin
        logic [15:0] w;
        w = (ost_r == rht_pkg::O_FILL_T) ? t_q_r : h_q_r;
        f_in_data = {w, crc8(w)};
    end
    rht_fifo #(.W(rht_pkg::WORD_W), .D(rht_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .flush_i(flush),
        .in_valid_i(f_in_valid),
        .in_ready_o(f_in_ready),
        .in_data_i(f_in_data),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_pop),
        .out_data_o(f_out_data)
    );

    ////////////////////////////////////////////////////////////////////
    chk_rst_bound: assert property (
        ost_r == rht_pkg::O_RST |-> tmr_r < 32'(RST_CNT))
        else $error("reset recovery too long");
    chk_low_meas: assert property (
        ost_r == rht_pkg::O_MEAS && rep_r == rht_pkg::REP_LOW
        |-> tmr_r < 32'(LOW_CNT)) else $error("measure too long");
    chk_heat_off: assert property (
        ost_r == rht_pkg::O_HEAT |-> heater_r && tmr_r < 32'(LONG_CNT))
        else $error("heater pulse too long");
    chk_busy_nack: assert property (
        bst_r == rht_pkg::B_ADDR && scl_fall && full_r && busy
        && sh_r == {TGT_ADDR, 1'b1} |=> bst_r == rht_pkg::B_SKIP
        ##1 sda_oe_n_o) else $error("read acked while busy");
    chk_crc_word: assert property (
        f_out_valid |-> f_out_data[7:0] == crc8(f_out_data[23:8]))
        else $error("bad checksum");
    chk_temp_first: assert property (
        f_in_valid && f_in_ready && ost_r == rht_pkg::O_FILL_T && !cmd_ev
        |=> ost_r == rht_pkg::O_FILL_H && f_in_data[23:8] == h_q_r)
        else $error("word order wrong");
    chk_heat_meas: assert property (
        ost_r == rht_pkg::O_HEAT && tmr_r == 32'h0 && !cmd_ev
        |=> ost_r == rht_pkg::O_MEAS && heater_r
        && rep_r == rht_pkg::REP_HIGH) else $error("heater measure wrong");
    chk_gc_reset: assert property (
        cmd_ev && gc_r && cmd == rht_pkg::GC_RESET
        |=> ost_r == rht_pkg::O_RST ##1 f_out_valid == 1'b0)
        else $error("general call reset missed");
endmodule : rht_target

//--- logic/rht_pkg.sv
// constants, command codes and state codes of the sensor command target
// assumes a single 100 MHz clock and an open-drain serial bus outside
package rht_pkg;
    localparam int CLK_MHZ = 100;
    // times in their own units, nominal or bounding figures
    localparam int SOFT_RESET_RECOVERY_TIME_US = 1000;
    localparam int LOW_REPEAT_MEASURE_TIME_US = 1600;
    localparam int MID_REPEAT_MEASURE_TIME_US = 4500;
    localparam int HIGH_REPEAT_MEASURE_TIME_US = 8300;
    localparam int HEATER_PULSE_TIME_LONG_MS = 1000;
    localparam int HEATER_PULSE_TIME_SHORT_MS = 100;
    localparam int US_PER_MS = 1000;
    // commands
    localparam logic [7:0] CMD_MEAS_HIGH = 8'hfd;
    localparam logic [7:0] CMD_MEAS_MID = 8'hf6;
    localparam logic [7:0] CMD_MEAS_LOW = 8'he0;
    localparam logic [7:0] CMD_SERIAL = 8'h89;
    localparam logic [7:0] CMD_SOFT_RST = 8'h94;
    localparam logic [7:0] CMD_HEAT_LONG_HI = 8'h39;
    localparam logic [7:0] CMD_HEAT_LONG_MID = 8'h2f;
    localparam logic [7:0] CMD_HEAT_LONG_LO = 8'h1e;
    localparam logic [7:0] CMD_HEAT_SHORT_HI = 8'h32;
    localparam logic [7:0] CMD_HEAT_SHORT_MID = 8'h24;
    localparam logic [7:0] CMD_HEAT_SHORT_LO = 8'h15;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [7:0] GC_RESET = 8'h06;
    // checksum
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_XOR = 8'h00;
    // repeatability and heater power codes
    localparam logic [1:0] REP_LOW = 2'h0;
    localparam logic [1:0] REP_MID = 2'h1;
    localparam logic [1:0] REP_HIGH = 2'h2;
    localparam logic [1:0] PWR_OFF = 2'h0;
    localparam logic [1:0] PWR_LO = 2'h1;
    localparam logic [1:0] PWR_MID = 2'h2;
    localparam logic [1:0] PWR_HI = 2'h3;
    // response buffer: word plus checksum, four entries
    localparam int WORD_W = 24;
    localparam int FIFO_DEPTH = 4;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    typedef enum logic [2:0] {
        B_IDLE = 3'h0, B_ADDR = 3'h1, B_ACK = 3'h2, B_WR = 3'h3,
        B_RD = 3'h4, B_MACK = 3'h5, B_SKIP = 3'h6
    } rht_bus_e;
    typedef enum logic [2:0] {
        O_IDLE = 3'h0, O_HEAT = 3'h1, O_MEAS = 3'h2,
        O_FILL_T = 3'h3, O_FILL_H = 3'h4, O_RST = 3'h5
    } rht_op_e;
endpackage : rht_pkg

//--- verification/rht_master.sv
// bus master model: start, stop, byte write, byte read with ack or nack
// assumes pull-ups on both lines; its clock runs only inside frames
`timescale 1ns/1ps
module rht_master (
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    localparam time QTR = 40ns; // quarter of the 160 ns link clock
    logic [7:0] rd_byte;
    event got;
    initial begin
        scl_o = 1'b1; // clock stands high between frames
        sda_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic start();
        sda_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b0;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask : start
    task automatic stop();
        sda_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b1;
        #QTR;
    endtask : stop
    // data moves only while the clock is low, sampled at its middle high
    task automatic pulse(input logic b, output logic r);
        sda_o = b;
        #QTR scl_o = 1'b1;
        #QTR r = sda_i;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask : pulse
    task automatic wr(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) pulse(b[i], r);
        pulse(1'b1, r);
        ack = ~r;
    endtask : wr
    task automatic rd(input logic last);
        logic r;
        for (int i = 0; i < 8; i++) begin
            pulse(1'b1, r);
            rd_byte = {rd_byte[6:0], r};
        end
        pulse(last, r);
        ->got;
    endtask : rd
endmodule : rht_master

//--- verification/rht_target_tb.sv
// self-checking bench of the sensor command target
// assumes the master model owns the bus; sensor words are random
`timescale 1ns/1ps
module rht_target_tb;
    localparam logic [6:0] ADDR = 7'h40;
    localparam int LO = 600, MI = 1200, HI = 2000, LG = 3000, SH = 1500;
    localparam int RS = 800;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, scl, sda_m, sda_o, sda_oe_n;
    logic meas_req, heat, busy;
    logic [1:0] rep, pwr;
    logic [15:0] t_w = 16'h0, h_w = 16'h0;
    logic [31:0] sn = 32'h0;
    wire sda = sda_m & (sda_oe_n ? 1'b1 : sda_o);
    logic [7:0] exp_q[$];
    int errors = 0, check_count = 0;
    logic [7:0] cmds[9] = '{8'hfd, 8'hf6, 8'he0, 8'h39, 8'h2f, 8'h1e,
        8'h32, 8'h24, 8'h15};
    logic [3:0] mode[9] = '{4'h8, 4'h4, 4'h0, 4'hb, 4'ha, 4'h9, 4'hb,
        4'ha, 4'h9}; // repeatability then heater power
    int lims[9] = '{HI, MI, LO, LG + HI, LG + HI, LG + HI, SH + HI,
        SH + HI, SH + HI};
    initial forever #5 ref_clk_i = ~ref_clk_i;
    rht_master u_m (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));
    rht_target #(.TGT_ADDR(ADDR), .RST_CNT(RS), .LOW_CNT(LO), .MID_CNT(MI),
        .HIGH_CNT(HI), .LONG_CNT(LG), .SHORT_CNT(SH)) u_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .temp_word_i(t_w),
        .relative_humidity_word_i(h_w), .serial_num_i(sn),
        .meas_req_o(meas_req), .meas_rep_o(rep), .heater_on_o(heat),
        .heater_pwr_o(pwr), .busy_o(busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen,
                want);
        end
    endtask : check
    task automatic stop_test();
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc8
    task automatic note(input logic [15:0] w);
        exp_q.push_back(w[15:8]);
        exp_q.push_back(w[7:0]);
        exp_q.push_back(crc8(w));
    endtask : note
    task automatic cmd(input logic [6:0] a, input logic [7:0] c);
        logic k;
        u_m.start();
        u_m.wr({a, 1'b0}, k);
        check({7'h0, k}, 8'h01);
        u_m.wr(c, k);
        check({7'h0, k}, 8'h01);
        u_m.stop();
    endtask : cmd
    // a refused header ends the frame at once, nothing is clocked out
    task automatic get(input int n, input logic acked);
        logic k;
        u_m.start();
        u_m.wr({ADDR, 1'b1}, k);
        check({7'h0, k}, {7'h0, acked});
        if (k) for (int i = 0; i < n; i++) u_m.rd(i == n - 1);
        u_m.stop();
    endtask : get
    task automatic wait_idle(input int lim, input logic [3:0] md,
        input logic ms);
        int n;
        logic prev;
        logic seen;
        n = 0;
        prev = 1'b0;
        seen = 1'b0;
        while (busy === 1'b1 && n < lim) begin
            @(negedge ref_clk_i);
            n++;
            // repeatability output lags the request by one cycle
            if (meas_req === 1'b1 && prev && n % 64 == 0) begin
                check({6'h0, rep}, {6'h0, md[3:2]});
                check({6'h0, pwr}, {6'h0, md[1:0]});
                check({7'h0, heat}, {7'h0, md[1:0] != 2'h0});
            end
            prev = meas_req;
            seen = seen | (meas_req === 1'b1);
        end
        check({7'h0, busy}, 8'h00);
        check({7'h0, heat}, 8'h00);
        check({7'h0, seen}, {7'h0, ms});
        check({7'h0, meas_req}, 8'h00);
        check({6'h0, pwr}, 8'h00);
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////////
    always @(u_m.got) begin
        if (exp_q.size() == 0) check(~u_m.rd_byte, u_m.rd_byte);
        else check(u_m.rd_byte, exp_q.pop_front());
    end
    initial begin
        #1ms;
        errors++;
        stop_test();
    end
    initial begin
        void'($urandom(28));
        repeat (5) @(posedge ref_clk_i);
        @(negedge ref_clk_i) rst_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        foreach (cmds[i]) begin
            t_w = 16'($urandom);
            h_w = 16'($urandom);
            cmd(ADDR, cmds[i]);
            get(1, 1'b0);
            wait_idle(lims[i] + 10, mode[i], 1'b1);
            note(t_w);
            note(h_w);
            get(6, 1'b1);
            exp_q.push_back(8'hff);
            get(1, 1'b1);
        end
        sn = $urandom;
        cmd(ADDR, 8'h89);
        wait_idle(20, 4'h0, 1'b0);
        note(sn[31:16]);
        note(sn[15:0]);
        get(6, 1'b1);
        cmd(ADDR, 8'he0);
        wait_idle(LO + 10, 4'h0, 1'b1);
        exp_q.push_back(t_w[15:8]);
        exp_q.push_back(t_w[7:0]);
        get(2, 1'b1);
        exp_q.push_back(8'hff);
        get(1, 1'b1);
        cmd(ADDR, 8'hfd);
        cmd(ADDR, 8'h94);
        wait_idle(RS + 10, 4'h8, 1'b0);
        exp_q.push_back(8'hff);
        get(1, 1'b1);
        cmd(ADDR, 8'hfd);
        wait_idle(HI + 10, 4'h8, 1'b1);
        cmd(7'h00, 8'h06);
        wait_idle(RS + 10, 4'h0, 1'b0);
        exp_q.push_back(8'hff);
        get(1, 1'b1);
        stop_test();
    end
endmodule : rht_target_tb
